// ---- src/tg_traffic_generator.sv ----
// Transmit traffic generator for framed, streaming and flow message traffic
`timescale 1ns/1ps
// What this block does
// - After reset and channel up, send LFSR words
// - Frame end from size and sent-byte counters
// - Frame size starts fixed, grows per frame
// - Byte strobe taken from low LFSR bits
// - Data state moves only on ready
// - Frame lengths vary, single-beat frames included
// - Data bus is 64 bits per lane
// - Strobe meaningful only with end marker
// - Beat taken only when valid and ready
// - Streaming drops delimiters, new word per ready
// - Streaming valid held high after one idle cycle
// - Raise flow request after channel up
// - Message size from zero up to 255
// - Flow valid after request, data on ready
// - Gap between messages set by parameter
// - Message never longer than 256 bytes
// - Flow data taken when valid and ready
// - Final beat uses leftmost needed bytes only
// - Dropped flow valid makes core insert idles
module tg_traffic_generator
#(
	parameter bit         STREAMING = 1'b0,
	parameter logic [7:0] MSG_GAP   = tg_pkg::MSG_GAP_DEFAULT
)
(
	// Clock and reset
	input  wire logic                      clock,
	input  wire logic                      rst,
	input  wire logic                      link_reset_n,
	input  wire logic                      channel_up,
	// Main transmit stream
	output tg_pkg::tg_stream_type          tx_stream,
	input  wire logic                      tx_stream_ready,
	// Flow message channel
	output tg_pkg::tg_flow_type            flow,
	input  wire logic                      user_flow_msg_ready
);

	// ************************************************************
	// Common run condition
	// ************************************************************
	logic run;

	assign run = !rst && link_reset_n && channel_up;

	// ************************************************************
	// Shared functions
	// ************************************************************

	// Taps chosen so that successive words do not repeat for a long run
	function automatic logic [15:0] lfsr_step(input logic [15:0] v);
		lfsr_step = {v[14:0], v[15] ^ v[14] ^ v[12] ^ v[3]};
	endfunction

	function automatic logic [tg_pkg::DATA_W-1:0] widen(input logic [15:0] v);
		widen = {tg_pkg::DATA_W/16{v}};
	endfunction

	// ************************************************************
	// Main stream state
	// ************************************************************
	tg_pkg::tg_frame_state_type fr_q, fr_d;
	logic [15:0] data_lfsr_q, data_lfsr_d;
	logic [7:0]  frame_size_q, frame_size_d;
	logic [7:0]  bytes_sent_q, bytes_sent_d;
	logic        accept;
	logic        end_beat;
	logic [8:0]  bytes_after;

	assign accept      = tx_stream.valid && tx_stream_ready;
	assign bytes_after = {1'b0, bytes_sent_q} + 9'(tg_pkg::BYTES);
	// Size counter in bytes; a size below one bus word yields a one-beat frame
	assign end_beat    = bytes_after > {1'b0, frame_size_q};

	always_comb
	begin
		fr_d          = fr_q;
		data_lfsr_d   = data_lfsr_q;
		frame_size_d  = frame_size_q;
		bytes_sent_d  = bytes_sent_q;
		if (!run)
		begin
			fr_d         = tg_pkg::FR_IDLE;
			data_lfsr_d  = tg_pkg::DATA_SEED;
			frame_size_d = tg_pkg::FRAME_SIZE_INIT;
			bytes_sent_d = 8'h00;
		end
		else
		begin
			unique case (fr_q)
				tg_pkg::FR_IDLE:
				begin
					fr_d = tg_pkg::FR_BODY;
				end
				tg_pkg::FR_BODY:
				begin
					if (accept)
					begin
						data_lfsr_d = lfsr_step(data_lfsr_q);
						if (!STREAMING && end_beat)
						begin
							fr_d         = tg_pkg::FR_DONE;
							bytes_sent_d = 8'h00;
						end
						else if (!STREAMING)
						begin
							bytes_sent_d = bytes_after[7:0];
						end
					end
				end
				tg_pkg::FR_DONE:
				begin
					frame_size_d = frame_size_q + 8'h01;
					fr_d         = tg_pkg::FR_BODY;
				end
			endcase
		end
	end

	// ************************************************************
	// Main stream registers
	// ************************************************************

	always_ff @(posedge clock)
	begin
		fr_q         <= fr_d;
		data_lfsr_q  <= data_lfsr_d;
		frame_size_q <= frame_size_d;
		bytes_sent_q <= bytes_sent_d;
	end

	// ************************************************************
	// Main stream outputs
	// ************************************************************

	always_comb
	begin
		tx_stream.data   = widen(data_lfsr_q);
		tx_stream.valid  = 1'b0;
		tx_stream.last   = 1'b0;
		tx_stream.strobe = '0;
		unique case (fr_q)
			tg_pkg::FR_BODY:
			begin
				tx_stream.valid = 1'b1;
				if (!STREAMING && end_beat)
				begin
					tx_stream.last   = 1'b1;
					// Strobe only driven with the end marker, low bits pick byte count
					tx_stream.strobe = data_lfsr_q[tg_pkg::STRB_W-1:0];
				end
			end
			tg_pkg::FR_IDLE,
			tg_pkg::FR_DONE:
			begin
				// Idle and gap cycles present nothing to the core
				tx_stream.valid = 1'b0;
			end
		endcase
	end

	// ************************************************************
	// Flow message state
	// ************************************************************
	tg_pkg::tg_flow_state_type fl_q, fl_d;
	logic [7:0]  gap_q, gap_d;
	logic [7:0]  msg_size_q, msg_size_d;
	logic [8:0]  msg_left_q, msg_left_d;
	logic [15:0] flow_lfsr_q, flow_lfsr_d;
	logic        flow_take;

	assign flow_take = flow.valid && user_flow_msg_ready;

	always_comb
	begin
		fl_d        = fl_q;
		gap_d       = gap_q;
		msg_size_d  = msg_size_q;
		msg_left_d  = msg_left_q;
		flow_lfsr_d = flow_lfsr_q;
		if (!run)
		begin
			fl_d        = tg_pkg::FL_GAP;
			gap_d       = MSG_GAP;
			msg_size_d  = tg_pkg::MSG_SIZE_INIT;
			msg_left_d  = 9'h000;
			flow_lfsr_d = tg_pkg::FLOW_SEED;
		end
		else
		begin
			unique case (fl_q)
				tg_pkg::FL_GAP:
				begin
					if (gap_q == 8'h00)
					begin
						fl_d = tg_pkg::FL_REQ;
					end
					else
					begin
						gap_d = gap_q - 8'h01;
					end
				end
				tg_pkg::FL_REQ:
				begin
					// Size field is bytes minus one, so at most 256 bytes go out
					msg_left_d = {1'b0, msg_size_q} + 9'h001;
					fl_d       = tg_pkg::FL_DATA;
				end
				tg_pkg::FL_DATA:
				begin
					if (flow_take)
					begin
						flow_lfsr_d = lfsr_step(flow_lfsr_q);
						// Last beat may carry fewer bytes; core uses leftmost ones
						if (msg_left_q <= 9'(tg_pkg::BYTES))
						begin
							fl_d = tg_pkg::FL_NEXT;
						end
						else
						begin
							msg_left_d = msg_left_q - 9'(tg_pkg::BYTES);
						end
					end
				end
				tg_pkg::FL_NEXT:
				begin
					// Size saturates so the byte count never passes 256
					if (msg_size_q != tg_pkg::MSG_SIZE_MAX)
					begin
						msg_size_d = msg_size_q + 8'h01;
					end
					gap_d = MSG_GAP;
					fl_d  = tg_pkg::FL_GAP;
				end
			endcase
		end
	end

	// ************************************************************
	// Flow message registers
	// ************************************************************

	always_ff @(posedge clock)
	begin
		fl_q        <= fl_d;
		gap_q       <= gap_d;
		msg_size_q  <= msg_size_d;
		msg_left_q  <= msg_left_d;
		flow_lfsr_q <= flow_lfsr_d;
	end

	// ************************************************************
	// Flow message outputs
	// ************************************************************

	// Valid held steady during data, so the core never has to insert idles
	always_comb
	begin
		flow.size    = msg_size_q;
		flow.payload = widen(flow_lfsr_q);
		flow.request = 1'b0;
		flow.valid   = 1'b0;
		unique case (fl_q)
			tg_pkg::FL_REQ:
			begin
				flow.request = 1'b1;
			end
			tg_pkg::FL_DATA:
			begin
				flow.valid = 1'b1;
			end
			tg_pkg::FL_GAP,
			tg_pkg::FL_NEXT:
			begin
				// Between messages the channel stays quiet
				flow.valid = 1'b0;
			end
		endcase
	end

endmodule

// ---- shared/tg_pkg.sv ----
// Package for the serial link transmit traffic generator
package tg_pkg;

	// Lane count and bus widths
	localparam int LANES       = 1;
	localparam int DATA_W      = 64 * LANES;
	localparam int STRB_W      = LANES;
	localparam int BYTES       = DATA_W / 8;

	// Counter widths and reset values
	localparam int          CNT_W          = 8;
	localparam logic [7:0]  FRAME_SIZE_INIT = 8'h00;
	localparam logic [7:0]  MSG_SIZE_INIT   = 8'h00;
	localparam logic [7:0]  MSG_SIZE_MAX    = 8'hFF;
	localparam logic [15:0] DATA_SEED       = 16'hABE0;
	localparam logic [15:0] FLOW_SEED       = 16'h1D5A;
	localparam logic [7:0]  MSG_GAP_DEFAULT = 8'h10;

	// Frame state machine, one-hot
	typedef enum logic [2:0]
	{
		FR_IDLE = 3'b001,
		FR_BODY = 3'b010,
		FR_DONE = 3'b100
	} tg_frame_state_type;

	// Flow message state machine, one-hot
	typedef enum logic [3:0]
	{
		FL_GAP  = 4'b0001,
		FL_REQ  = 4'b0010,
		FL_DATA = 4'b0100,
		FL_NEXT = 4'b1000
	} tg_flow_state_type;

	// Main transmit stream beat
	typedef struct packed
	{
		logic [DATA_W-1:0] data;
		logic [STRB_W-1:0] strobe;
		logic              last;
		logic              valid;
	} tg_stream_type;

	// Flow message channel towards the core
	typedef struct packed
	{
		logic              request;
		logic [7:0]        size;
		logic [DATA_W-1:0] payload;
		logic              valid;
	} tg_flow_type;

endpackage

// ---- bench/tg_checker.sv ----
// Port assertions for the traffic generator
`timescale 1ns/1ps
module tg_checker
#(
	parameter bit STREAMING = 1'b0
)
(
	// Watched ports
	input wire logic                  clock,
	input wire logic                  rst,
	input wire logic                  link_reset_n,
	input wire logic                  channel_up,
	input wire tg_pkg::tg_stream_type tx_stream,
	input wire logic                  tx_stream_ready,
	input wire tg_pkg::tg_flow_type   flow,
	input wire logic                  user_flow_msg_ready
);
	wire up = link_reset_n && channel_up;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	held_beat_a: assert property (up && tx_stream.valid && !tx_stream_ready |=> $stable(tx_stream))
		else $error("stalled beat moved");
	down_quiet_a: assert property (!up |=> !tx_stream.valid && !flow.valid && !flow.request)
		else $error("active while down");
	strobe_end_a: assert property (tx_stream.strobe != '0 |-> tx_stream.last)
		else $error("strobe without end");
	req_pulse_a: assert property (flow.request |=> !flow.request)
		else $error("request too long");
	flow_start_a: assert property (up && flow.request |=> flow.valid)
		else $error("no flow valid");
	flow_hold_a: assert property (up && flow.valid && !user_flow_msg_ready |=> flow.valid && $stable(flow.payload))
		else $error("flow beat moved");
	frame_gap_a: assert property (!STREAMING && tx_stream.last && tx_stream.valid && tx_stream_ready |=> !tx_stream.valid)
		else $error("no gap after frame");
	stream_on_a: assert property (STREAMING && up && tx_stream.valid |=> tx_stream.valid)
		else $error("stream valid fell");
	stream_bare_a: assert property (STREAMING |-> !tx_stream.last && tx_stream.strobe == '0)
		else $error("stream delimiter");
	cover property (tx_stream.valid && tx_stream.last && tx_stream_ready);
	cover property (tx_stream.valid && !tx_stream_ready);
	cover property (flow.request && flow.size == 8'hFF);
endmodule
bind tg_traffic_generator tg_checker #(.STREAMING(STREAMING)) i_chk (.clock(clock), .rst(rst),
	.link_reset_n(link_reset_n), .channel_up(channel_up), .tx_stream(tx_stream),
	.tx_stream_ready(tx_stream_ready), .flow(flow), .user_flow_msg_ready(user_flow_msg_ready));

// ---- bench/tg_core_model.sv ----
// Behavioural link core transmit side
`timescale 1ns/1ps
module tg_core_model
(
	// Clock, reset, stalling
	input  wire logic                clock,
	input  wire logic                rst,
	input  wire logic                slow,
	// Generator side
	input  wire tg_pkg::tg_flow_type flow,
	output logic                     tx_stream_ready,
	output logic                     user_flow_msg_ready
);
	logic [5:0] left_q;
	logic       wait_q;
	logic       tick_q;
	// Slow adds one cycle, still inside the two-cycle bound
	assign user_flow_msg_ready = left_q != 6'h00 && !wait_q;
	assign tx_stream_ready = !user_flow_msg_ready && !(slow && tick_q);
	always_ff @(posedge clock)
	begin
		tick_q <= !tick_q;
		if (rst)
		begin
			// Stall phase starts known so ready never goes unknown
			tick_q <= 1'b0;
			left_q <= 6'h00;
			wait_q <= 1'b0;
		end
		else if (flow.request)
		begin
			left_q <= 6'((9'(flow.size) + 9'h008) >> 3);
			wait_q <= slow;
		end
		else
		begin
			wait_q <= 1'b0;
			if (flow.valid && user_flow_msg_ready)
				left_q <= left_q - 6'h01;
		end
	end
endmodule

// ---- bench/tg_traffic_generator_tb.sv ----
// Bench for the traffic generator
`timescale 1ns/1ps
module tg_traffic_generator_tb;
	logic                  clock = 1'b0;
	logic                  rst = 1'b1;
	logic                  link_reset_n = 1'b1;
	logic                  channel_up = 1'b1;
	logic                  slow = 1'b0;
	logic                  rdy, frdy;
	tg_pkg::tg_stream_type tx, stx;
	tg_pkg::tg_flow_type   fl, sfl;
	logic [7:0]            msg_n;
	logic [5:0]            left;
	logic [63:0]           prev = '0;
	logic [63:0]           prev_pay = '0;
	logic                  was_rdy = 1'b0;
	int                    miscompares = 0;
	int                    num_checks = 0;
	int                    msgs = 0;
	int                    n;
	int                    beats_row [18] = '{1,1,1,1,1,1,1,1,2,2,2,2,2,2,2,2,3,3};
	wire                   down = rst || !channel_up || !link_reset_n;
	always #2.5 clock = ~clock;
	tg_traffic_generator #(.MSG_GAP(8'h02)) i_dut (.clock(clock), .rst(rst),
		.link_reset_n(link_reset_n), .channel_up(channel_up), .tx_stream(tx),
		.tx_stream_ready(rdy), .flow(fl), .user_flow_msg_ready(frdy));
	tg_traffic_generator #(.STREAMING(1'b1)) i_dut_stream (.clock(clock), .rst(rst),
		.link_reset_n(link_reset_n), .channel_up(channel_up), .tx_stream(stx),
		.tx_stream_ready(rdy), .flow(sfl), .user_flow_msg_ready(frdy));
	tg_core_model i_core (.clock(clock), .rst(down), .slow(slow), .flow(fl),
		.tx_stream_ready(rdy), .user_flow_msg_ready(frdy));
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge clock)
	begin
		if (down)
		begin
			msg_n <= 8'h00;
			left <= 6'h00;
			prev_pay <= '0;
		end
		else if (fl.request)
		begin
			check(fl.size, msg_n);
			check(left, 6'h00);
			msg_n <= (msg_n == 8'hFF) ? msg_n : msg_n + 8'h01;
			left <= 6'((9'(msg_n) + 9'h008) >> 3);
			msgs++;
		end
		else if (fl.valid && frdy)
		begin
			check(left != 6'h00, 1'b1);
			check(fl.payload != prev_pay, 1'b1);
			prev_pay <= fl.payload;
			left <= left - 6'h01;
		end
	end
	initial
	begin
		repeat (20000) @(posedge clock);
		miscompares++;
		print_verdict();
	end
	initial
	begin
		repeat (5) @(negedge clock);
		rst = 1'b0;
		for (int r = 0; r < 18; r++)
		begin
			@(negedge clock) slow = r[0];
			n = 0;
			do
			begin
				@(posedge clock);
				if (tx.valid && rdy)
				begin
					n++;
					check(tx.data != prev, 1'b1);
					prev = tx.data;
					if (tx.last)
						check(tx.strobe, tx.data[0]);
				end
			end while (!(tx.valid && rdy && tx.last));
			check(n, beats_row[r]);
		end
		@(posedge clock);
		prev = stx.data;
		was_rdy = rdy;
		repeat (20)
		begin
			@(posedge clock);
			check(stx.valid, 1'b1);
			// Word moves only after an edge where ready was high
			if (was_rdy)
				check(stx.data != prev, 1'b1);
			else
				check(stx.data, prev);
			prev = stx.data;
			was_rdy = rdy;
		end
		@(negedge clock) channel_up = 1'b0;
		@(negedge clock) link_reset_n = 1'b0;
		channel_up = 1'b1;
		@(posedge clock) check({tx.valid, fl.valid, fl.request}, 3'h0);
		@(negedge clock) link_reset_n = 1'b1;
		for (n = 0; n < 15000 && msgs < 300; n++)
			@(posedge clock);
		check(msg_n, 8'hFF);
		print_verdict();
	end
endmodule
